// ---- core/lock_gate_pkg.sv ----
package lock_gate_pkg;

  // wishbone register byte offsets
  localparam logic [3:0] STATUS_OFFSET     = 4'h0; // lock state, fuses seen
  localparam logic [3:0] FILL_OFFSET       = 4'h4; // data given on denied reads
  localparam logic [3:0] DENY_CNT_OFFSET   = 4'h8; // denied debug accesses
  localparam logic [3:0] LOCK_KEY_OFFSET   = 4'hc; // lock_key_fuse mirror

  // fuse offset of lock_key_fuse in the fuse area
  localparam logic [7:0] LOCK_KEY_FUSE_OFFSET = 8'h0a;

  // status field positions
  localparam int STATUS_LOCKED_BIT  = 0;
  localparam int STATUS_ERASING_BIT = 1;
  localparam int STATUS_BOOT_LSB    = 8;

  // key value that opens the device; also the factory value after an erase
  localparam logic [7:0] LOCK_KEY_OPEN = 8'hc5;

  // flash blocks of 256 bytes: block number is address shifted by this
  localparam int BOOT_BLOCK_SHIFT = 8;
  // boot end value meaning the whole flash is boot
  localparam logic [7:0] BOOT_END_ALL = 8'h00;

  // reset values
  localparam logic [7:0]  FILL_RESET     = 8'hff;
  localparam logic [15:0] DENY_CNT_RESET = 16'h0000;

  // memory sections a request can address
  typedef enum logic [3:0] {
    SEC_SRAM    = 4'h0,
    SEC_REGS    = 4'h1,
    SEC_FLASH   = 4'h2,
    SEC_EEPROM  = 4'h3,
    SEC_USER_ROW_AREA = 4'h4,
    SEC_SIGNATURE_ROW_AREA  = 4'h5,
    SEC_FUSES   = 4'h6,
    SEC_DBG_CS  = 4'h7, // debug port's own control and status space
    SEC_ASI     = 4'h8  // async_sys_iface
  } section_type;

  // lock gate sequencing
  typedef enum logic [2:0] {
    ST_LOAD  = 3'b001,
    ST_RUN   = 3'b010,
    ST_ERASE = 3'b100
  } gate_state_type;

endpackage

// ---- core/access_req_if.sv ----
// one access request as seen by the policy decider
interface access_req_if;
  import lock_gate_pkg::*;
  section_type section;    // target section
  logic        we;         // write when high
  logic        from_debug; // debug_port origin, else processor
  logic        fuse_cmd;   // issued with the fuse write command
  logic        locked;     // current lock state
  logic        allow;      // decision

  modport requester (output section, output we, output from_debug,
                     output fuse_cmd, output locked, input allow);
  modport decider (input section, input we, input from_debug,
                   input fuse_cmd, input locked, output allow);
endinterface

// ---- core/access_policy.sv ----
// pure access table for one requester
module access_policy
  import lock_gate_pkg::*;
(
  access_req_if.decider req
);

  // table lookup, no state
  always_comb begin
    req.allow = 1'b0;
    if (!req.from_debug) begin
      // processor: same rights locked or open
      case (req.section)
        SEC_SIGNATURE_ROW_AREA: req.allow = !req.we;
        SEC_FUSES:  req.allow = !req.we;
        SEC_DBG_CS: req.allow = 1'b0;    // not a processor target
        SEC_ASI:    req.allow = 1'b0;
        default:    req.allow = 1'b1;
      endcase
    end else if (!req.locked) begin
      // open debug port
      case (req.section)
        SEC_SIGNATURE_ROW_AREA: req.allow = !req.we;
        default:    req.allow = 1'b1;
      endcase
    end else begin
      // locked debug port: own space reads only, plus blind user row writes
      case (req.section)
        SEC_DBG_CS:  req.allow = !req.we;
        SEC_ASI:     req.allow = !req.we;
        SEC_USER_ROW_AREA: req.allow = req.we && req.fuse_cmd;
        default:     req.allow = 1'b0;
      endcase
    end
  end

endmodule

// ---- core/debug_access_lock_gate.sv ----
// Function
// - boot end counts 256-byte blocks; zero means all
// - open only when lock key equals c5
// - locked debug port reads only own space; writes only blind user row
// - processor access unaffected by lock
// - open: debug full access; signature row read-only
// - locked: debug denied all main memories
// - locked: blind user row fuse-command writes allowed
// - only full erase unlocks, restoring factory contents
// - locked erase always clears eeprom
//
// The implementer's own choice: the Wishbone interface to the registers.
module debug_access_lock_gate
  import lock_gate_pkg::*;
#(
  parameter int FLASH_AW = 16 // flash byte address width
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // fuse values presented by the fuse loader during reset
  input  wire logic [7:0]          lock_key_fuse_i,
  input  wire logic [7:0]          boot_region_end_i,
  input  wire logic                eeprom_keep_on_erase_i,
  // full erase sequence from the nvm controller
  input  wire logic                full_erase_start_i,
  input  wire logic                full_erase_done_i,
  output logic                     erase_eeprom_o,
  // processor requests
  input  wire logic                cpu_req_i,
  input  wire logic                cpu_we_i,
  input  wire logic [3:0]          cpu_section_i,
  output logic                     cpu_grant_o,
  // debug_port requests
  input  wire logic                dbg_req_i,
  input  wire logic                dbg_we_i,
  input  wire logic                dbg_fuse_cmd_i,
  input  wire logic [3:0]          dbg_section_i,
  input  wire logic [7:0]          dbg_mem_rdata_i,
  output logic                     dbg_grant_o,
  output logic [7:0]               dbg_rdata_o,
  // flash boot region classification and lock state
  input  wire logic [FLASH_AW-1:0] flash_addr_i,
  output logic                     flash_in_boot_o,
  output logic                     locked_o,
  // classic wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [3:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic [31:0]              dat_o,
  output logic                     ack_o
);

  gate_state_type state_q;      // sequencing state
  logic [7:0]     lock_key_q;   // key captured at reset release
  logic [7:0]     boot_end_q;   // boot end captured at reset release
  logic           keep_ee_q;    // eeprom keep fuse captured
  logic           locked;       // decoded lock state
  logic [7:0]     fill_q;       // value returned on denied reads
  logic [15:0]    deny_cnt_q;   // denied debug accesses
  logic           dbg_denied;   // current debug request refused
  logic           erase_ee_q;   // eeprom erase order
  logic           in_boot_q;    // registered boot classification
  logic [7:0]     dbg_rdata_q;  // debug read data
  logic           ack_q;        // bus answer
  logic [31:0]    dat_q;        // bus read data
  logic           bus_wr;       // accepted write this cycle
  logic           cnt_clear;    // software clears the deny counter

  access_req_if cpu_req ();
  access_req_if dbg_req ();

  // any key other than the open one locks, which is how a programmer locks
  assign locked = (lock_key_q != LOCK_KEY_OPEN);

  // sequencing: load fuses once after reset, then run; erase blocks debug
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_LOAD;
    end else begin
      case (state_q)
        ST_LOAD:  state_q <= ST_RUN;
        ST_RUN: begin
          if (full_erase_start_i) begin
            state_q <= ST_ERASE;
          end
        end
        ST_ERASE: begin
          if (full_erase_done_i) begin
            state_q <= ST_RUN;
          end
        end
        default:  state_q <= ST_LOAD;
      endcase
    end
  end

  // fuse capture: held until next reset or erase, never from live pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_key_q <= 8'h00; // safe default: locked until fuses are seen
      boot_end_q <= BOOT_END_ALL;
      keep_ee_q  <= 1'b0;
    end else if (state_q == ST_LOAD) begin
      lock_key_q <= lock_key_fuse_i;
      boot_end_q <= boot_region_end_i;
      keep_ee_q  <= eeprom_keep_on_erase_i;
    end else if (state_q == ST_ERASE && full_erase_done_i) begin
      // erased fuses return to factory content, which opens the part
      lock_key_q <= LOCK_KEY_OPEN;
      boot_end_q <= BOOT_END_ALL;
      keep_ee_q  <= 1'b0;
    end
  end

  // eeprom erase order, taken when the erase begins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_ee_q <= 1'b0;
    end else if (state_q == ST_RUN && full_erase_start_i) begin
      erase_ee_q <= locked || !keep_ee_q;
    end else if (state_q != ST_ERASE || full_erase_done_i) begin
      erase_ee_q <= 1'b0; // order ends with the erase, not a cycle later
    end
  end

  // boot region: block index below the end, or zero means whole flash
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_boot_q <= 1'b1;
    end else begin
      in_boot_q <= (boot_end_q == BOOT_END_ALL) ||
                   (FLASH_AW'(flash_addr_i >> BOOT_BLOCK_SHIFT) <
                    FLASH_AW'(boot_end_q));
    end
  end

  // request routing into the policy tables
  assign cpu_req.section    = section_type'(cpu_section_i);
  assign cpu_req.we         = cpu_we_i;
  assign cpu_req.from_debug = 1'b0;
  assign cpu_req.fuse_cmd   = 1'b0;
  assign cpu_req.locked     = locked; // ignored for processor
  assign dbg_req.section    = section_type'(dbg_section_i);
  assign dbg_req.we         = dbg_we_i;
  assign dbg_req.from_debug = 1'b1;
  assign dbg_req.fuse_cmd   = dbg_fuse_cmd_i;
  assign dbg_req.locked     = locked;

  access_policy u_cpu_policy (
    .req (cpu_req)
  );

  access_policy u_dbg_policy (
    .req (dbg_req)
  );

  // grants are combinational handshakes; no debug grant before fuses load
  assign cpu_grant_o = cpu_req_i && cpu_req.allow;
  assign dbg_denied  = dbg_req_i && (!dbg_req.allow || state_q != ST_RUN);
  assign dbg_grant_o = dbg_req_i && !dbg_denied;

  // denied reads still answer, with fill data, so nothing leaks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbg_rdata_q <= 8'h00;
    end else if (dbg_req_i && !dbg_we_i) begin
      dbg_rdata_q <= dbg_denied ? fill_q : dbg_mem_rdata_i;
    end
  end

  // wishbone: one wait state, ack drops the cycle after it rose
  assign bus_wr    = cyc_i && stb_i && we_i && !ack_q;
  assign cnt_clear = bus_wr && adr_i == DENY_CNT_OFFSET && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  // fill register, low byte lane only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fill_q <= FILL_RESET;
    end else if (bus_wr && adr_i == FILL_OFFSET && sel_i[0]) begin
      fill_q <= dat_i[7:0];
    end
  end

  // deny counter saturates; a refusal in the clear cycle still counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deny_cnt_q <= DENY_CNT_RESET;
    end else if (dbg_denied) begin
      if (cnt_clear) begin
        deny_cnt_q <= 16'h0001;
      end else if (deny_cnt_q != 16'hffff) begin
        deny_cnt_q <= deny_cnt_q + 16'h0001;
      end
    end else if (cnt_clear) begin
      deny_cnt_q <= DENY_CNT_RESET;
    end
  end

  // read data mux, registered with the ack; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_q) begin
      case (adr_i)
        STATUS_OFFSET: begin
          dat_q                       <= 32'h0000_0000;
          dat_q[STATUS_LOCKED_BIT]    <= locked;
          dat_q[STATUS_ERASING_BIT]   <= (state_q == ST_ERASE);
          dat_q[STATUS_BOOT_LSB +: 8] <= boot_end_q;
        end
        FILL_OFFSET:     dat_q <= {24'h00_0000, fill_q};
        DENY_CNT_OFFSET: dat_q <= {16'h0000, deny_cnt_q};
        LOCK_KEY_OFFSET: dat_q <= {24'h00_0000, lock_key_q};
        default:         dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o           = ack_q;
  assign dat_o           = dat_q;
  assign dbg_rdata_o     = dbg_rdata_q;
  assign erase_eeprom_o  = erase_ee_q;
  assign flash_in_boot_o = in_boot_q;
  assign locked_o        = locked;

endmodule

// ---- testbench/dbg_host_model.sv ----
// external debugger: one request at a time on the debug_port
module dbg_host_model
  import lock_gate_pkg::*;
(
  input  logic       clk_i,
  input  logic       grant_i,
  output logic       req_o,
  output logic       we_o,
  output logic       fuse_cmd_o,
  output logic [3:0] section_o,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // memory byte tagged by section so a stale byte shows
  assign mem_rdata_o = {4'ha, section_o};
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    fuse_cmd_o = 1'b0;
    section_o = 4'h0;
  end
  // hold one cycle; a denied read byte is never trusted
  task automatic access(input logic [3:0] s, input logic w, input logic fc, output logic g);
    @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= w;
    fuse_cmd_o <= fc;
    section_o <= s;
    @(posedge clk_i);
    g = grant_i;
    req_o <= 1'b0;
    section_o <= ~s; // released section lines do not keep the last value; we_o and fuse_cmd_o do
  endtask
endmodule

// ---- testbench/debug_access_lock_gate_assertions.sv ----
module lock_gate_checker
  import lock_gate_pkg::*;
(
  input logic       clk_i,
  input logic       rst_i,
  input logic [7:0] lock_key_fuse_i,
  input logic       full_erase_start_i,
  input logic       full_erase_done_i,
  input logic       erase_eeprom_o,
  input logic       cpu_req_i,
  input logic       cpu_we_i,
  input logic [3:0] cpu_section_i,
  input logic       cpu_grant_o,
  input logic       dbg_req_i,
  input logic       dbg_we_i,
  input logic       dbg_fuse_cmd_i,
  input logic [3:0] dbg_section_i,
  input logic [7:0] dbg_mem_rdata_i,
  input logic       dbg_grant_o,
  input logic [7:0] dbg_rdata_o,
  input logic       locked_o,
  input logic       cyc_i,
  input logic       stb_i,
  input logic       ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic busy_q; // erase running; blind check starts after the load cycle
  logic blind;  // user row write with the fuse command
  assign blind = dbg_we_i && dbg_fuse_cmd_i && dbg_section_i == 4'h4;
  // erase tracking from start and done pins
  always_ff @(posedge clk_i) begin
    if (rst_i) busy_q <= 1'b0;
    else if (busy_q) busy_q <= !full_erase_done_i;
    else busy_q <= full_erase_start_i;
  end
  a_key_opens: assert property (
    $fell(rst_i) |=> locked_o == ($past(lock_key_fuse_i) != LOCK_KEY_OPEN))
    else $error("lock state differs from key");
  a_lock_held: assert property (
    !$past(rst_i) && !$past(rst_i, 2) && !$past(full_erase_done_i) |-> $stable(locked_o))
    else $error("lock state moved");
  a_cpu_allowed: assert property (
    cpu_req_i && (cpu_section_i < 4'h5 || !cpu_we_i && cpu_section_i < 4'h7) |-> cpu_grant_o)
    else $error("cpu access refused");
  a_cpu_no_fuse: assert property (
    cpu_req_i && cpu_we_i && cpu_section_i inside {4'h5, 4'h6} |-> !cpu_grant_o)
    else $error("cpu wrote fuse or signature");
  a_locked_deny: assert property (
    locked_o && dbg_grant_o |-> blind || !dbg_we_i && dbg_section_i inside {4'h7, 4'h8})
    else $error("locked debug access granted");
  a_sig_read_only: assert property (
    !locked_o && dbg_req_i && dbg_we_i && dbg_section_i == 4'h5 |-> !dbg_grant_o)
    else $error("signature row written");
  a_read_passes: assert property (
    dbg_req_i && !dbg_we_i && dbg_grant_o |=> dbg_rdata_o == $past(dbg_mem_rdata_i))
    else $error("granted read data lost");
  a_blind_write: assert property (
    !busy_q && !$past(rst_i) && locked_o && dbg_req_i && blind |-> dbg_grant_o)
    else $error("blind user row write refused");
  a_erase_eeprom: assert property (
    !busy_q && !$past(rst_i) && full_erase_start_i && locked_o |=> erase_eeprom_o)
    else $error("locked erase keeps eeprom");
  a_erase_unlocks: assert property (
    busy_q && full_erase_done_i |=> !locked_o && !erase_eeprom_o)
    else $error("erase did not unlock");
  a_erase_gates: assert property (
    busy_q |-> !dbg_grant_o)
    else $error("debug granted during erase");
  a_ack_answers: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  a_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("ack held too long");
  c_erase_done: cover property (busy_q && full_erase_done_i);
  c_locked_grant: cover property (locked_o && dbg_grant_o);
  c_denied_read: cover property (dbg_req_i && !dbg_we_i && !dbg_grant_o);
endmodule

bind debug_access_lock_gate lock_gate_checker checker_inst (
  .clk_i, .rst_i, .lock_key_fuse_i, .full_erase_start_i, .full_erase_done_i,
  .erase_eeprom_o, .cpu_req_i, .cpu_we_i, .cpu_section_i, .cpu_grant_o, .dbg_req_i,
  .dbg_we_i, .dbg_fuse_cmd_i, .dbg_section_i, .dbg_mem_rdata_i, .dbg_grant_o,
  .dbg_rdata_o, .locked_o, .cyc_i, .stb_i, .ack_o
);

// ---- testbench/test_debug_access_lock_gate.sv ----
module test_debug_access_lock_gate
  import lock_gate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, keep = 1'b1, es = 1'b0, ed = 1'b0;
  logic        cpu_req = 1'b0, cpu_we = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        g, erase_ee, cpu_grant, dreq, dwe, dfc, dgrant, locked, in_boot, ack;
  logic [3:0]  cpu_sec = 4'h0, adr = 4'h0, dsec;
  logic [7:0]  key = 8'h00, boot = 8'h00, mem, rdata;
  logic [15:0] faddr = 16'h0000;
  logic [31:0] dat = 32'h0, q, wb_dat;
  int          num_errors = 0, comparisons = 0;
  always #4 clk_i = ~clk_i;
  debug_access_lock_gate uut (
    .clk_i, .rst_i, .lock_key_fuse_i(key), .boot_region_end_i(boot),
    .eeprom_keep_on_erase_i(keep), .full_erase_start_i(es), .full_erase_done_i(ed),
    .erase_eeprom_o(erase_ee), .cpu_req_i(cpu_req), .cpu_we_i(cpu_we),
    .cpu_section_i(cpu_sec), .cpu_grant_o(cpu_grant), .dbg_req_i(dreq), .dbg_we_i(dwe),
    .dbg_fuse_cmd_i(dfc), .dbg_section_i(dsec), .dbg_mem_rdata_i(mem),
    .dbg_grant_o(dgrant), .dbg_rdata_o(rdata), .flash_addr_i(faddr),
    .flash_in_boot_o(in_boot), .locked_o(locked), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(wb_dat), .ack_o(ack));
  dbg_host_model host (.clk_i, .grant_i(dgrant), .req_o(dreq), .we_o(dwe),
    .fuse_cmd_o(dfc), .section_o(dsec), .mem_rdata_o(mem));
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  // fuses held through reset, then load cycle and first run cycle
  task automatic boot_up(input logic [7:0] k, input logic [7:0] b);
    @(posedge clk_i);
    key <= k;
    boot <= b;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // classic cycle: hold until ack is seen, bounded wait
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 16) begin
      num_errors++;
      results();
    end
  endtask
  task automatic cpu(input logic [3:0] s, input logic w, input logic e);
    @(posedge clk_i);
    cpu_req <= 1'b1;
    cpu_we <= w;
    cpu_sec <= s;
    @(posedge clk_i);
    chk(cpu_grant, e);
    cpu_req <= 1'b0;
  endtask
  // grant checked in its cycle, read byte one edge later
  task automatic dbg(input logic [3:0] s, input logic w, input logic fc, input logic e,
                     input logic [7:0] fill);
    host.access(s, w, fc, g);
    chk(g, e);
    #1;
    if (!w) chk(rdata, e ? {4'ha, s} : fill);
  endtask
  task automatic bootchk(input logic [15:0] a, input logic e);
    @(posedge clk_i);
    faddr <= a;
    @(posedge clk_i);
    #1;
    chk(in_boot, e);
  endtask
  task automatic t_open();
    boot_up(LOCK_KEY_OPEN, 8'h03);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    chk(q, 32'h0300);
    wb(1'b1, FILL_OFFSET, 32'h5a);
    wb(1'b0, FILL_OFFSET, 32'h0);
    chk(q, 32'h5a);
    wb(1'b1, LOCK_KEY_OFFSET, 32'h0);
    wb(1'b0, LOCK_KEY_OFFSET, 32'h0);
    chk(q, 32'hc5);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    bootchk(16'h02ff, 1'b1);
    bootchk(16'h0300, 1'b0);
    dbg(SEC_SIGNATURE_ROW_AREA, 1'b0, 1'b0, 1'b1, 8'h5a);
    dbg(SEC_SIGNATURE_ROW_AREA, 1'b1, 1'b0, 1'b0, 8'h5a);
    dbg(SEC_FUSES, 1'b1, 1'b0, 1'b1, 8'h5a);
    cpu(SEC_FUSES, 1'b1, 1'b0);
    $display("open test done");
  endtask
  task automatic t_locked();
    boot_up(8'hc4, 8'h00);
    chk(locked, 1'b1);
    bootchk(16'hffff, 1'b1);
    for (int s = 0; s < 7; s++) dbg(s[3:0], 1'b0, 1'b0, 1'b0, 8'hff);
    dbg(SEC_DBG_CS, 1'b0, 1'b0, 1'b1, 8'hff);
    dbg(SEC_ASI, 1'b0, 1'b0, 1'b1, 8'hff);
    dbg(SEC_USER_ROW_AREA, 1'b1, 1'b1, 1'b1, 8'hff);
    dbg(SEC_USER_ROW_AREA, 1'b1, 1'b0, 1'b0, 8'hff);
    dbg(SEC_FLASH, 1'b1, 1'b1, 1'b0, 8'hff);
    cpu(SEC_SRAM, 1'b1, 1'b1);
    cpu(SEC_SIGNATURE_ROW_AREA, 1'b0, 1'b1);
    wb(1'b0, DENY_CNT_OFFSET, 32'h0);
    chk(q, 32'h9);
    wb(1'b1, DENY_CNT_OFFSET, 32'h0);
    wb(1'b0, DENY_CNT_OFFSET, 32'h0);
    chk(q, 32'h0);
    key <= LOCK_KEY_OPEN;
    repeat (3) @(posedge clk_i);
    chk(locked, 1'b1);
    $display("locked test done");
  endtask
  task automatic t_erase();
    boot_up(8'h00, 8'h04);
    @(posedge clk_i);
    es <= 1'b1;
    @(posedge clk_i);
    es <= 1'b0;
    #1;
    chk(erase_ee, 1'b1);
    dbg(SEC_DBG_CS, 1'b0, 1'b0, 1'b0, 8'hff);
    @(posedge clk_i);
    ed <= 1'b1;
    @(posedge clk_i);
    ed <= 1'b0;
    #1;
    chk({locked, erase_ee}, 2'b00);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    chk(q, 32'h0);
    dbg(SEC_FLASH, 1'b0, 1'b0, 1'b1, 8'hff);
    // open part with the keep fuse set: eeprom survives the erase
    boot_up(LOCK_KEY_OPEN, 8'h00);
    @(posedge clk_i);
    es <= 1'b1;
    @(posedge clk_i);
    es <= 1'b0;
    #1;
    chk(erase_ee, 1'b0);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    chk(q, 32'h2);
    @(posedge clk_i);
    ed <= 1'b1;
    @(posedge clk_i);
    ed <= 1'b0;
    #1;
    chk({locked, erase_ee}, 2'b00);
    $display("erase test done");
  endtask
  initial begin
    t_open();
    t_locked();
    t_erase();
    results();
  end
endmodule
